// ---- rtl/ampc_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface ampc_cfg_if;
    logic       modulation_bd;
    logic [1:0] slave_shift;
    logic       stagger_off;
    logic       clock_double;
    modport src (output modulation_bd, slave_shift, stagger_off,
                 clock_double);
    modport dst (input modulation_bd, slave_shift, stagger_off,
                 clock_double);
endinterface // ampc_cfg_if
`default_nettype wire

// ---- rtl/ampc_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module ampc_ctrl
    import ampc_pkg::*;
#(
    parameter int unsigned RETRY_COUNT = RETRY_CYCLES
)(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  osc_set_strap,
    input  wire logic                  spread_pll_strap,
    input  wire logic [1:0]            mode_strap,
    input  wire logic [3:0]            addr_select_strap,
    input  wire logic                  shared_clock_pin_in,
    input  wire logic                  osc_tick,
    input  wire logic                  host_wr,
    input  wire logic                  modulation_select_bit,
    input  wire logic [1:0]            slave_shift_field,
    input  wire logic                  stagger_disable_bit,
    input  wire logic                  clock_double_bit,
    input  wire logic                  offset_enable_bit_a,
    input  wire logic                  offset_enable_bit_b,
    input  wire logic                  undervolt_level_bit,
    input  wire logic                  enable_pin,
    input  wire logic                  host_standby_exit,
    input  wire logic                  thermal_foldback,
    input  wire logic                  thermal_shutdown,
    input  wire logic                  overtemp_trip,
    input  wire logic [NUM_CH-1:0]     overcurrent_trip,
    input  wire logic [NUM_CH-1:0]     load_short,
    input  wire logic [NUM_CH-1:0]     supply_short,
    input  wire logic [NUM_CH-1:0]     terminal_short,
    input  wire logic [NUM_CH-1:0]     dc_over_2v,
    input  wire logic                  analog_below_8v,
    input  wire logic                  ramp_filter_grounded,
    input  wire logic                  below_6v,
    input  wire logic                  overvolt_trip,
    output logic                       shared_clock_pin_out,
    output logic                       shared_clock_pin_oe,
    output logic                       clock_master,
    output logic                       spread_enable,
    output logic                       pll_enable,
    output logic                       bus_mode,
    output logic [3:0]                 bus_address,
    output logic                       modulation_bd,
    output logic [1:0]                 phase_shift,
    output logic                       pair34_stagger,
    output logic                       gain_reduce,
    output logic                       mute,
    output logic                       discharge_caps,
    output logic [NUM_CH-1:0]          stage_enable,
    output logic [NUM_CH-1:0]          current_limit,
    output logic [NUM_CH-1:0]          window_active,
    output logic                       offset_guard,
    output logic                       undervolt_guard,
    output logic                       overvolt_guard,
    output ampc_state_t                state
);
    ampc_cfg_if cfg ();

    ////////////////////////////////////////////////////////////////////////
    // Host configuration bits
    logic       mod_reg;
    logic [1:0] shift_reg;
    logic       stag_reg;
    logic       dbl_reg;
    logic       offa_reg;
    logic       offb_reg;
    logic       uvlvl_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mod_reg   <= 1'b0;
            shift_reg <= 2'h0;
            stag_reg  <= 1'b0;
            dbl_reg   <= 1'b0;
            offa_reg  <= 1'b0;
            offb_reg  <= 1'b0;
            uvlvl_reg <= 1'b0;
        end
        else if (host_wr && bus_mode)
        begin
            mod_reg   <= modulation_select_bit;
            shift_reg <= slave_shift_field;
            stag_reg  <= stagger_disable_bit;
            dbl_reg   <= clock_double_bit;
            offa_reg  <= offset_enable_bit_a;
            offb_reg  <= offset_enable_bit_b;
            uvlvl_reg <= undervolt_level_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap latch, frozen while undervoltage active
    logic       bus_reg;
    logic [1:0] mstrap_reg;
    logic [3:0] addr_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_reg    <= 1'b0;
            mstrap_reg <= 2'h0;
            addr_reg   <= 4'h0;
        end
        else if (!undervolt_guard)
        begin
            bus_reg    <= (addr_select_strap != 4'h0);
            mstrap_reg <= mode_strap;
            addr_reg   <= addr_select_strap;
        end
    end
    assign bus_mode    = bus_reg;
    assign bus_address = addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and modulation selection
    wire logic strap_bd    = mstrap_reg[0];
    wire logic strap_shift = mstrap_reg[1];
    assign cfg.modulation_bd = bus_reg ? mod_reg : strap_bd;
    assign cfg.clock_double  = bus_reg & dbl_reg;
    assign cfg.stagger_off   = bus_reg & stag_reg;
    assign cfg.slave_shift   = bus_reg ? shift_reg
                             : (strap_shift ? SHIFT_2_8 : SHIFT_NONE);

    assign clock_master   = osc_set_strap;
    assign spread_enable  = osc_set_strap & spread_pll_strap;
    assign pll_enable     = ~osc_set_strap & spread_pll_strap;
    assign modulation_bd  = cfg.modulation_bd;
    assign phase_shift    = pll_enable ? cfg.slave_shift : SHIFT_NONE;
    assign pair34_stagger = ~cfg.stagger_off;

    logic half_reg;
    logic clk_out_reg;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_reg    <= 1'b0;
            clk_out_reg <= 1'b0;
        end
        else if (osc_tick)
        begin
            half_reg    <= ~half_reg;
            clk_out_reg <= cfg.clock_double ? ~clk_out_reg
                                            : (half_reg ? ~clk_out_reg
                                                        : clk_out_reg);
        end
    end
    assign shared_clock_pin_out = clk_out_reg;
    assign shared_clock_pin_oe  = clock_master;

    ////////////////////////////////////////////////////////////////////////
    // Supply and thermal guards, combinational
    assign undervolt_guard = below_6v | (uvlvl_reg & analog_below_8v);
    assign overvolt_guard  = overvolt_trip;
    wire logic supply_fault = undervolt_guard | overvolt_guard;
    wire logic hard_off = overtemp_trip | thermal_shutdown | supply_fault;
    assign gain_reduce     = thermal_foldback & ~hard_off;
    assign discharge_caps  = supply_fault;
    assign offset_guard = (offa_reg | offb_reg) & ~analog_below_8v
                        & ~ramp_filter_grounded & (|dc_over_2v)
                        & (state == AMPC_MUTE || state == AMPC_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequence
    ampc_state_t state_reg;
    ampc_state_t state_next;
    logic [NUM_CH-1:0] ready_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            AMPC_OFF:
                if (enable_pin)
                    state_next = bus_reg ? AMPC_STANDBY : AMPC_CHECK;
            AMPC_STANDBY:
                if (host_standby_exit)
                    state_next = AMPC_CHECK;
            AMPC_CHECK:
                state_next = AMPC_MUTE;
            AMPC_MUTE:
                state_next = AMPC_RUN;
            AMPC_RUN:
                state_next = AMPC_RUN;
            default:
                state_next = AMPC_OFF;
        endcase
        if (!enable_pin || supply_fault)
            state_next = AMPC_OFF;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= AMPC_OFF;
            ready_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == AMPC_OFF)
                ready_reg <= '0;
            else if (state_reg != AMPC_STANDBY)
                ready_reg <= ready_reg | ~terminal_short;
        end
    end
    assign state = state_reg;
    assign mute  = (state_reg != AMPC_RUN) | undervolt_guard;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel short retry
    logic [NUM_CH-1:0] chan_off;
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            ampc_retry #(.RETRY_COUNT(RETRY_COUNT)) u_retry (
                .sys_clk      (sys_clk),
                .rst_n        (rst_n),
                .short_in     (load_short[ch] | supply_short[ch]),
                .supply_short (supply_short[ch]),
                .chan_off     (chan_off[ch]),
                .window_hold  (window_active[ch])
            );
        end
    endgenerate

    wire logic running = (state_reg == AMPC_MUTE) || (state_reg == AMPC_RUN);
    assign stage_enable = (running && !hard_off) ? (ready_reg & ~chan_off)
                                                 : '0;
    assign current_limit = overcurrent_trip & ~load_short & ~supply_short;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_otp_all_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        overtemp_trip |-> stage_enable == '0)
        else $error("stage enabled during overtemperature");
    chk_no_dbl_nobus: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !bus_reg |-> !cfg.clock_double)
        else $error("clock doubling outside bus mode");
    chk_strap_frozen: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        undervolt_guard |=> $stable(mstrap_reg) && $stable(addr_reg))
        else $error("straps changed during undervoltage");
    chk_uv_mutes: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        undervolt_guard |-> mute ##1 state_reg == AMPC_OFF)
        else $error("undervoltage did not mute and stop");
    chk_nobus_mute: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        state_reg == AMPC_OFF && enable_pin && !bus_reg && !supply_fault
        |=> state_reg == AMPC_CHECK ##1 state_reg == AMPC_MUTE)
        else $error("no-bus enable did not reach mute");
    chk_short_halt: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        state_reg == AMPC_CHECK && terminal_short[2] |=> !stage_enable[2])
        else $error("shorted channel started");
    chk_ocp_limits: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        overcurrent_trip[0] && !load_short[0] && !supply_short[0]
        |-> current_limit[0])
        else $error("current limit missing");
    chk_offset_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        analog_below_8v || ramp_filter_grounded |-> !offset_guard)
        else $error("offset guard active while forced off");
    chk_stagger_def: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !stag_reg |-> pair34_stagger)
        else $error("stagger lost by default");
    cov_run: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == AMPC_MUTE ##1 state_reg == AMPC_RUN);
    cov_retry: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(chan_off[0]));
    cov_window: cover property (@(posedge sys_clk) disable iff (!rst_n)
        window_active[1]);
    cov_foldback: cover property (@(posedge sys_clk) disable iff (!rst_n)
        gain_reduce && state_reg == AMPC_RUN);
endmodule // ampc_ctrl
`default_nettype wire

// ---- rtl/ampc_pkg.sv ----
package ampc_pkg;
    // Decoded mode strap codes
    localparam logic [1:0] MODE_AD_NOSHIFT = 2'h0;
    localparam logic [1:0] MODE_BD_NOSHIFT = 2'h1;
    localparam logic [1:0] MODE_AD_SHIFT   = 2'h2;
    localparam logic [1:0] MODE_BD_SHIFT   = 2'h3;
    // Slave shift codes, eighths of pi
    localparam logic [1:0] SHIFT_NONE      = 2'h0;
    localparam logic [1:0] SHIFT_2_8       = 2'h2;
    // Retry timing
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned RETRY_MS       = 50;
    localparam int unsigned RETRY_CYCLES   = RETRY_MS * 1000 * CLK_MHZ;
    localparam int unsigned RETRY_W        = 24;
    localparam int unsigned NUM_CH         = 4;
    typedef enum logic [2:0] {
        AMPC_OFF, AMPC_STANDBY, AMPC_CHECK, AMPC_MUTE, AMPC_RUN
    } ampc_state_t;
endpackage : ampc_pkg

// ---- rtl/ampc_retry.sv ----
`timescale 1ns/10ps
`default_nettype none
module ampc_retry
    import ampc_pkg::*;
#(
    parameter int unsigned RETRY_COUNT = RETRY_CYCLES
)(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic short_in,
    input  wire logic supply_short,
    output logic      chan_off,
    output logic      window_hold
);
    logic [RETRY_W-1:0] cnt_reg;
    logic               off_reg;
    logic               win_reg;
    wire  logic         expired = (cnt_reg == '0);

    // Off on short; a load short restarts the interval at each expiry while it persists, a supply short holds off until it clears
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            off_reg <= 1'b0;
            win_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else if (!off_reg)
        begin
            if (short_in)
            begin
                off_reg <= 1'b1;
                win_reg <= supply_short;
                cnt_reg <= RETRY_W'(RETRY_COUNT - 1);
            end
        end
        else if (!expired)
            cnt_reg <= cnt_reg - 1'b1;
        else if (win_reg && supply_short)
            off_reg <= 1'b1;
        else if (short_in && !win_reg)
            cnt_reg <= RETRY_W'(RETRY_COUNT - 1);
        else
        begin
            off_reg <= 1'b0;
            win_reg <= 1'b0;
        end
    end
    assign chan_off    = off_reg;
    assign window_hold = win_reg;

    chk_win_holds_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        off_reg && win_reg && supply_short |=> off_reg)
        else $error("window hold released during supply short");
endmodule // ampc_retry
`default_nettype wire

// ---- verif/ampc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ampc_host_model
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       req,
    input  wire logic [7:0] cfg,
    output logic            host_wr,
    output logic            modulation_select_bit,
    output logic [1:0]      slave_shift_field,
    output logic            stagger_disable_bit,
    output logic            clock_double_bit,
    output logic            offset_enable_bit_a,
    output logic            offset_enable_bit_b,
    output logic            undervolt_level_bit
);
    logic [7:0] bits_reg;
    ////////////////////////////////////////////////////////////////////////
    // Strobe and data move together; data holds until the next write
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_wr  <= 1'b0;
            bits_reg <= 8'h00;
        end
        else
        begin
            host_wr <= req;
            if (req)
            begin
                bits_reg <= cfg;
            end
        end
    end
    assign {undervolt_level_bit, offset_enable_bit_b, offset_enable_bit_a,
            clock_double_bit, stagger_disable_bit, slave_shift_field,
            modulation_select_bit} = bits_reg;
endmodule // ampc_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ampc_pkg::*;
    localparam int unsigned RC = 16;
    logic              sys_clk = 1'b0;
    logic              rst_n, osc_set_strap, spread_pll_strap, osc_tick;
    logic              shared_clock_pin_in, host_wr, host_standby_exit;
    logic              modulation_select_bit, stagger_disable_bit, req;
    logic              clock_double_bit, offset_enable_bit_a, enable_pin;
    logic              offset_enable_bit_b, undervolt_level_bit;
    logic              thermal_foldback, thermal_shutdown, overtemp_trip;
    logic              analog_below_8v, ramp_filter_grounded, below_6v;
    logic              overvolt_trip, shared_clock_pin_out;
    logic              shared_clock_pin_oe, clock_master, spread_enable;
    logic              pll_enable, bus_mode, modulation_bd, pair34_stagger;
    logic              gain_reduce, mute, discharge_caps, offset_guard;
    logic              undervolt_guard, overvolt_guard;
    logic [1:0]        mode_strap, slave_shift_field, phase_shift;
    logic [3:0]        addr_select_strap, bus_address;
    logic [NUM_CH-1:0] overcurrent_trip, load_short, supply_short;
    logic [NUM_CH-1:0] terminal_short, dc_over_2v, stage_enable;
    logic [NUM_CH-1:0] current_limit, window_active;
    logic [7:0]        cfg;
    ampc_state_t       state;
    int                miscompares = 0;
    int                total_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    ampc_ctrl #(.RETRY_COUNT(RC)) uut (
        .sys_clk, .rst_n, .osc_set_strap, .spread_pll_strap, .mode_strap,
        .addr_select_strap, .shared_clock_pin_in, .osc_tick, .host_wr,
        .modulation_select_bit, .slave_shift_field, .stagger_disable_bit,
        .clock_double_bit, .offset_enable_bit_a, .offset_enable_bit_b,
        .undervolt_level_bit, .enable_pin, .host_standby_exit,
        .thermal_foldback, .thermal_shutdown, .overtemp_trip,
        .overcurrent_trip, .load_short, .supply_short, .terminal_short,
        .dc_over_2v, .analog_below_8v, .ramp_filter_grounded, .below_6v,
        .overvolt_trip, .shared_clock_pin_out, .shared_clock_pin_oe,
        .clock_master, .spread_enable, .pll_enable, .bus_mode, .bus_address,
        .modulation_bd, .phase_shift, .pair34_stagger, .gain_reduce, .mute,
        .discharge_caps, .stage_enable, .current_limit, .window_active,
        .offset_guard, .undervolt_guard, .overvolt_guard, .state
    );
    ampc_host_model host (
        .sys_clk, .rst_n, .req, .cfg, .host_wr, .modulation_select_bit,
        .slave_shift_field, .stagger_disable_bit, .clock_double_bit,
        .offset_enable_bit_a, .offset_enable_bit_b, .undervolt_level_bit
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic look();
        @(negedge sys_clk);
    endtask
    task automatic settle();
        cyc(2);
        look();
    endtask
    task automatic host_write(input logic [7:0] v);
        cyc(1);
        req <= 1'b1;
        cfg <= v;
        cyc(1);
        req <= 1'b0;
        settle();
    endtask
    task automatic wait_stage(input logic [3:0] exp, input int bound);
        int k;
        k = 0;
        while (stage_enable !== exp && k < bound)
        begin
            look();
            k++;
        end
        chk(stage_enable, exp);
        if (stage_enable !== exp) test_done();
    endtask
    // Counts pin edges over eight oscillator events
    task automatic clk_count(input logic [7:0] exp);
        logic last;
        int   n;
        n = 0;
        last = shared_clock_pin_out;
        for (int k = 0; k < 20; k++)
        begin
            @(posedge sys_clk);
            osc_tick <= (k < 16) && !k[0];
            look();
            if (shared_clock_pin_out !== last) n++;
            last = shared_clock_pin_out;
        end
        chk(n[7:0], exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ampc_state_t seq [3];
        seq = '{AMPC_CHECK, AMPC_MUTE, AMPC_RUN};
        {rst_n, osc_set_strap, osc_tick, shared_clock_pin_in, enable_pin,
         host_standby_exit, thermal_foldback, thermal_shutdown, req,
         overtemp_trip, analog_below_8v, ramp_filter_grounded, below_6v,
         overvolt_trip, mode_strap, addr_select_strap, overcurrent_trip,
         load_short, supply_short, terminal_short, dc_over_2v, cfg} <= '0;
        spread_pll_strap <= 1'b1;
        cyc(20);
        rst_n <= 1'b1;
        settle();
        chk(state, AMPC_OFF);
        chk(stage_enable, 4'h0);
        chk(pair34_stagger, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            cyc(1);
            osc_set_strap <= i[1];
            spread_pll_strap <= i[0];
            settle();
            chk(shared_clock_pin_oe, i[1]);
            chk(clock_master, i[1]);
            chk(i[1] ? spread_enable : pll_enable, i[0]);
        end
        cyc(1);
        osc_set_strap <= 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            cyc(1);
            mode_strap <= m[1:0];
            settle();
            chk(modulation_bd, m[0]);
            chk(phase_shift, m[1] ? SHIFT_2_8 : SHIFT_NONE);
        end
        host_write(8'h10);
        chk(modulation_bd, 1'b1);
        cyc(1);
        osc_set_strap <= 1'b1;
        clk_count(8'h04);
        cyc(1);
        enable_pin <= 1'b1;
        cyc(1);
        look();
        chk(state, AMPC_CHECK);
        cyc(1);
        enable_pin <= 1'b0;
        cyc(1);
        look();
        chk(state, AMPC_OFF);
        cyc(1);
        osc_set_strap <= 1'b0;
        addr_select_strap <= 4'h5;
        settle();
        chk(bus_mode, 1'b1);
        chk(bus_address, 4'h5);
        chk(modulation_bd, 1'b0);
        chk(phase_shift, SHIFT_NONE);
        for (int s = 1; s < 4; s++)
        begin
            host_write({5'h00, s[1:0], s[0]});
            chk(modulation_bd, s[0]);
            chk(phase_shift, s[1:0]);
            chk(pair34_stagger, 1'b1);
        end
        host_write(8'h08);
        chk(pair34_stagger, 1'b0);
        cyc(1);
        osc_set_strap <= 1'b1;
        host_write(8'h00);
        clk_count(8'h04);
        host_write(8'h10);
        clk_count(8'h08);
        cyc(1);
        enable_pin <= 1'b1;
        terminal_short <= 4'h4;
        cyc(4);
        look();
        chk(state, AMPC_STANDBY);
        cyc(1);
        host_standby_exit <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            cyc(1);
            look();
            chk(state, seq[i]);
        end
        chk(stage_enable, 4'hb);
        cyc(1);
        terminal_short <= 4'h0;
        wait_stage(4'hf, 4);
        for (int i = 0; i < 3; i++)
        begin
            cyc(1);
            {overtemp_trip, thermal_shutdown, thermal_foldback} <= 3'h1 << i;
            look();
            chk(stage_enable, (i == 0) ? 4'hf : 4'h0);
            if (i == 0) chk(gain_reduce, 1'b1);
            cyc(1);
            {overtemp_trip, thermal_shutdown, thermal_foldback} <= 3'h0;
            wait_stage(4'hf, 4);
        end
        cyc(1);
        overcurrent_trip <= 4'h3;
        look();
        chk(current_limit, 4'h3);
        chk(stage_enable, 4'hf);
        cyc(1);
        overcurrent_trip <= 4'h0;
        for (int p = 0; p < 2; p++)
        begin
            cyc(1);
            load_short <= 4'h1;
            cyc(2);
            load_short <= p ? 4'h1 : 4'h0;
            look();
            chk(stage_enable, 4'he);
            cyc(p ? 2 * RC : RC - 4);
            look();
            chk(stage_enable, 4'he);
            cyc(1);
            load_short <= 4'h0;
            wait_stage(4'hf, RC + 4);
        end
        cyc(1);
        supply_short <= 4'h2;
        cyc(RC + 6);
        look();
        chk(window_active[1], 1'b1);
        chk(stage_enable, 4'hd);
        cyc(1);
        supply_short <= 4'h0;
        wait_stage(4'hf, RC + 4);
        cyc(1);
        dc_over_2v <= 4'h2;
        for (int i = 0; i < 5; i++)
        begin
            host_write({1'b0, i == 2, i != 0 && i != 2, 5'h00});
            cyc(1);
            analog_below_8v <= (i == 3);
            ramp_filter_grounded <= (i == 4);
            settle();
            chk(offset_guard, i == 1 || i == 2);
            chk(undervolt_guard, 1'b0);
        end
        cyc(1);
        {analog_below_8v, ramp_filter_grounded} <= 2'h0;
        below_6v <= 1'b1;
        look();
        chk(undervolt_guard, 1'b1);
        chk(mute, 1'b1);
        chk(discharge_caps, 1'b1);
        chk(stage_enable, 4'h0);
        cyc(1);
        addr_select_strap <= 4'h9;
        settle();
        chk(state, AMPC_OFF);
        chk(bus_address, 4'h5);
        cyc(1);
        below_6v <= 1'b0;
        wait_stage(4'hf, 10);
        chk(bus_address, 4'h9);
        host_write(8'h80);
        cyc(1);
        analog_below_8v <= 1'b1;
        look();
        chk(undervolt_guard, 1'b1);
        cyc(1);
        analog_below_8v <= 1'b0;
        wait_stage(4'hf, 10);
        cyc(1);
        overvolt_trip <= 1'b1;
        look();
        chk(overvolt_guard, 1'b1);
        chk(stage_enable, 4'h0);
        chk(discharge_caps, 1'b1);
        cyc(1);
        overvolt_trip <= 1'b0;
        wait_stage(4'hf, 10);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
